// File: verilog/dtc_pkg.sv
/*
 * dtc_pkg: constants shared by the dual timer/counter block.
 * assumes an 8-bit special function register port with byte addresses.
 */
package dtc_pkg;
	// register byte addresses
	localparam logic [7:0] dtc_addr_ctl = 8'h88;
	localparam logic [7:0] dtc_addr_mode = 8'h89;
	localparam logic [7:0] dtc_addr_low_a = 8'h8a;
	localparam logic [7:0] dtc_addr_low_b = 8'h8b;
	localparam logic [7:0] dtc_addr_high_a = 8'h8c;
	localparam logic [7:0] dtc_addr_high_b = 8'h8d;
	// control register bit positions
	localparam int dtc_bit_type_a = 0;
	localparam int dtc_bit_eirq_a = 1;
	localparam int dtc_bit_type_b = 2;
	localparam int dtc_bit_eirq_b = 3;
	localparam int dtc_bit_run_a = 4;
	localparam int dtc_bit_ovf_a = 5;
	localparam int dtc_bit_run_b = 6;
	localparam int dtc_bit_ovf_b = 7;
	// mode nibble bit positions, within the nibble
	localparam int dtc_nib_mode_lo = 0;
	localparam int dtc_nib_mode_hi = 1;
	localparam int dtc_nib_src = 2;
	localparam int dtc_nib_gate = 3;
	// reset values
	localparam logic [7:0] dtc_rst_byte = 8'h00;
	// prescaler width in mode 0
	localparam int dtc_presc_bits = 5;
	// operating modes, in mode field encoding order
	typedef enum logic [1:0] {
		dtc_mode_13bit,
		dtc_mode_16bit,
		dtc_mode_reload,
		dtc_mode_split
	} dtc_mode_t;
endpackage

// File: verilog/dtc_pin_sync.sv
/*
 * dtc_pin_sync: three-stage synchroniser with a falling-edge strobe.
 * assumes an asynchronous pin; the level counts once stages two and
 * three agree, so the first stage feeds only the second.
 */
`timescale 1ns/1ps
module dtc_pin_sync (
	input wire logic clock,
	input wire logic resetn,
	input wire logic pin,
	output logic level,
	output logic fall
);
	logic [2:0] sync_q; // shift chain, bit 0 is the first stage
	logic [2:0] sync_d;
	logic level_q; // agreed level
	logic level_d;

	// next values: shift, adopt level only when stages agree
	always_comb begin
		sync_d = {sync_q[1:0], pin};
		level_d = (sync_q[1] == sync_q[2]) ? sync_q[2] : level_q;
	end

	// registers only; idle level high, as for a pulled-up pin
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			sync_q <= 3'h7;
			level_q <= 1'b1;
		end else begin
			sync_q <= sync_d;
			level_q <= level_d;
		end
	end

	assign level = level_q;
	// high sample then low sample is one count event
	assign fall = level_q & ~level_d;
endmodule // dtc_pin_sync

// File: verilog/dtc_timer.sv
/*
 * dtc_timer: two 16-bit timer/counters, mode and control registers,
 * external interrupt flags, reachable over an 8-bit register port.
 * assumes the port is driven from the same clock; one peripheral
 * cycle per clock edge; the interrupt controller pulses an ack.
 */
// Functional notes
// - timer a uses low mode nibble, bits 0145
// - timer b uses high mode nibble, bits 2367
// - gate set needs pin high to count
// - run bit starts and stops timer
// - rollover sets overflow flag, requests interrupt
// - vectoring ack clears overflow flag
// - mode 0 is 13-bit, 5-bit prescaler
// - mode 1 cascades low into high byte
// - mode 2 reloads low from high byte
// - timer a mode 3 low byte normal
// - mode 3 high byte uses b run/flag
// - timer b mirrors timer a modes 0-2; here timer b halts while timer a is in mode 3
// - timer b mode 3 holds its count
// - two-bit mode field decode 00..11
// - pin sets irq flag, edge clears on ack
// - timer b overflow feeds serial baud clock
// - timer mode counts every peripheral cycle
// - counter mode counts sampled falling edges
`timescale 1ns/1ps
module dtc_timer (
	input wire logic clock,
	input wire logic resetn,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire logic count_pin_a,
	input wire logic count_pin_b,
	input wire logic ext_gate_pin_a,
	input wire logic ext_gate_pin_b,
	input wire logic ack_ovf_a,
	input wire logic ack_ovf_b,
	input wire logic ack_eirq_a,
	input wire logic ack_eirq_b,
	output logic irq_ovf_a,
	output logic irq_ovf_b,
	output logic irq_ext_a,
	output logic irq_ext_b,
	output logic baud_tick
);
	logic [7:0] ctl_q, ctl_d; // timer_control_flags
	logic [7:0] mode_q, mode_d; // timer_mode_select
	logic [7:0] count_low_a_q, count_low_a_d;
	logic [7:0] count_high_a_q, count_high_a_d;
	logic [7:0] count_low_b_q, count_low_b_d;
	logic [7:0] count_high_b_q, count_high_b_d;
	logic baud_q, baud_d; // registered overflow of timer b
	logic cnt_fall_a, cnt_fall_b; // count pins only need the edge
	logic gate_lvl_a, gate_lvl_b, gate_fall_a, gate_fall_b;
	logic [3:0] nib_a, nib_b;
	dtc_pkg::dtc_mode_t mode_a, mode_b;
	logic en_a, en_b, en_split_hi;
	logic ovf_a, ovf_b;
	logic [8:0] sum_la, sum_ha, sum_lb, sum_hb;
	logic [5:0] psc_a, psc_b;
	logic set_eirq_a, set_eirq_b;

	// synchronisers for all four outside pins
	dtc_pin_sync u_cnt_a (.clock(clock), .resetn(resetn),
		.pin(count_pin_a), .level(), .fall(cnt_fall_a));
	dtc_pin_sync u_cnt_b (.clock(clock), .resetn(resetn),
		.pin(count_pin_b), .level(), .fall(cnt_fall_b));
	dtc_pin_sync u_gate_a (.clock(clock), .resetn(resetn),
		.pin(ext_gate_pin_a), .level(gate_lvl_a), .fall(gate_fall_a));
	dtc_pin_sync u_gate_b (.clock(clock), .resetn(resetn),
		.pin(ext_gate_pin_b), .level(gate_lvl_b), .fall(gate_fall_b));

	// mode nibbles and decoded modes
	assign nib_a = mode_q[3:0];
	assign nib_b = mode_q[7:4];
	assign mode_a = dtc_pkg::dtc_mode_t'(nib_a[1:0]);
	assign mode_b = dtc_pkg::dtc_mode_t'(nib_b[1:0]);

	// count enables: run bit, gate and input select
	// the gate pin is active high here; it is an interrupt pin so
	// low means asserted for the flag, but counting needs it high
	always_comb begin
		en_a = ctl_q[dtc_pkg::dtc_bit_run_a]
			& (~nib_a[dtc_pkg::dtc_nib_gate] | gate_lvl_a)
			& (nib_a[dtc_pkg::dtc_nib_src] ? cnt_fall_a
			: 1'b1);
		en_b = ctl_q[dtc_pkg::dtc_bit_run_b]
			& (~nib_b[dtc_pkg::dtc_nib_gate] | gate_lvl_b)
			& (nib_b[dtc_pkg::dtc_nib_src] ? cnt_fall_b : 1'b1)
			& (mode_b != dtc_pkg::dtc_mode_split)
			& (mode_a != dtc_pkg::dtc_mode_split);
		// split high byte: peripheral clock, timer b run bit
		en_split_hi = ctl_q[dtc_pkg::dtc_bit_run_b]
			& (mode_a == dtc_pkg::dtc_mode_split);
	end

	// incremented values, widened for the carry
	assign sum_la = {1'b0, count_low_a_q} + 9'h001;
	assign sum_ha = {1'b0, count_high_a_q} + 9'h001;
	assign sum_lb = {1'b0, count_low_b_q} + 9'h001;
	assign sum_hb = {1'b0, count_high_b_q} + 9'h001;
	assign psc_a = {1'b0, count_low_a_q[4:0]} + 6'h01;
	assign psc_b = {1'b0, count_low_b_q[4:0]} + 6'h01;
	assign set_eirq_a = ctl_q[dtc_pkg::dtc_bit_type_a] ? gate_fall_a
		: ~gate_lvl_a;
	assign set_eirq_b = ctl_q[dtc_pkg::dtc_bit_type_b] ? gate_fall_b
		: ~gate_lvl_b;

	// counting, register writes and flag updates
	always_comb begin
		count_low_a_d = count_low_a_q;
		count_high_a_d = count_high_a_q;
		count_low_b_d = count_low_b_q;
		count_high_b_d = count_high_b_q;
		ovf_a = 1'b0;
		ovf_b = 1'b0;
		// timer a low byte and high byte
		if (en_a) begin
			case (mode_a)
			dtc_pkg::dtc_mode_13bit: begin
				// upper three low bits are left as they are
				count_low_a_d[4:0] = psc_a[4:0];
				if (psc_a[dtc_pkg::dtc_presc_bits]) begin
					count_high_a_d = sum_ha[7:0];
					ovf_a = sum_ha[8];
				end
			end
			dtc_pkg::dtc_mode_16bit: begin
				count_low_a_d = sum_la[7:0];
				if (sum_la[8]) begin
					count_high_a_d = sum_ha[7:0];
					ovf_a = sum_ha[8];
				end
			end
			dtc_pkg::dtc_mode_reload: begin
				// reload takes whatever high byte holds now
				count_low_a_d = sum_la[8] ? count_high_a_q
					: sum_la[7:0];
				ovf_a = sum_la[8];
			end
			dtc_pkg::dtc_mode_split: begin
				count_low_a_d = sum_la[7:0];
				ovf_a = sum_la[8];
			end
			default: begin
				count_low_a_d = count_low_a_q;
			end
			endcase
		end
		if (en_split_hi) begin
			count_high_a_d = sum_ha[7:0];
			ovf_b = sum_ha[8];
		end
		// timer b, same arithmetic as timer a in modes 0-2
		if (en_b) begin
			case (mode_b)
			dtc_pkg::dtc_mode_13bit: begin
				count_low_b_d[4:0] = psc_b[4:0];
				if (psc_b[dtc_pkg::dtc_presc_bits]) begin
					count_high_b_d = sum_hb[7:0];
					ovf_b = sum_hb[8];
				end
			end
			dtc_pkg::dtc_mode_16bit: begin
				count_low_b_d = sum_lb[7:0];
				if (sum_lb[8]) begin
					count_high_b_d = sum_hb[7:0];
					ovf_b = sum_hb[8];
				end
			end
			dtc_pkg::dtc_mode_reload: begin
				count_low_b_d = sum_lb[8] ? count_high_b_q
					: sum_lb[7:0];
				ovf_b = sum_lb[8];
			end
			default: begin
				count_low_b_d = count_low_b_q;
			end
			endcase
		end
		// software writes override counting in the same cycle
		if (reg_wr) begin
			case (reg_addr)
			dtc_pkg::dtc_addr_low_a: count_low_a_d = reg_wdata;
			dtc_pkg::dtc_addr_high_a: count_high_a_d = reg_wdata;
			dtc_pkg::dtc_addr_low_b: count_low_b_d = reg_wdata;
			dtc_pkg::dtc_addr_high_b: count_high_b_d = reg_wdata;
			default: begin
			end
			endcase
		end
	end

	// control, mode and baud registers; hardware set beats clears
	always_comb begin
		ctl_d = ctl_q;
		mode_d = mode_q;
		if (reg_wr && reg_addr == dtc_pkg::dtc_addr_ctl) begin
			ctl_d = reg_wdata;
		end
		if (reg_wr && reg_addr == dtc_pkg::dtc_addr_mode) begin
			mode_d = reg_wdata;
		end
		if (ack_ovf_a) begin
			ctl_d[dtc_pkg::dtc_bit_ovf_a] = 1'b0;
		end
		if (ack_ovf_b) begin
			ctl_d[dtc_pkg::dtc_bit_ovf_b] = 1'b0;
		end
		// edge-type flags clear on ack; level flags follow the pin
		if (ack_eirq_a && ctl_q[dtc_pkg::dtc_bit_type_a]) begin
			ctl_d[dtc_pkg::dtc_bit_eirq_a] = 1'b0;
		end
		if (ack_eirq_b && ctl_q[dtc_pkg::dtc_bit_type_b]) begin
			ctl_d[dtc_pkg::dtc_bit_eirq_b] = 1'b0;
		end
		if (!ctl_q[dtc_pkg::dtc_bit_type_a]) begin
			ctl_d[dtc_pkg::dtc_bit_eirq_a] = ~gate_lvl_a;
		end
		if (!ctl_q[dtc_pkg::dtc_bit_type_b]) begin
			ctl_d[dtc_pkg::dtc_bit_eirq_b] = ~gate_lvl_b;
		end
		if (set_eirq_a) begin
			ctl_d[dtc_pkg::dtc_bit_eirq_a] = 1'b1;
		end
		if (set_eirq_b) begin
			ctl_d[dtc_pkg::dtc_bit_eirq_b] = 1'b1;
		end
		if (ovf_a) begin
			ctl_d[dtc_pkg::dtc_bit_ovf_a] = 1'b1;
		end
		if (ovf_b) begin
			ctl_d[dtc_pkg::dtc_bit_ovf_b] = 1'b1;
		end
		// baud source is timer b's own overflow only
		baud_d = en_b & ovf_b;
	end

	// registers
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			ctl_q <= dtc_pkg::dtc_rst_byte;
			mode_q <= dtc_pkg::dtc_rst_byte;
			count_low_a_q <= dtc_pkg::dtc_rst_byte;
			count_high_a_q <= dtc_pkg::dtc_rst_byte;
			count_low_b_q <= dtc_pkg::dtc_rst_byte;
			count_high_b_q <= dtc_pkg::dtc_rst_byte;
			baud_q <= 1'b0;
		end else begin
			ctl_q <= ctl_d;
			mode_q <= mode_d;
			count_low_a_q <= count_low_a_d;
			count_high_a_q <= count_high_a_d;
			count_low_b_q <= count_low_b_d;
			count_high_b_q <= count_high_b_d;
			baud_q <= baud_d;
		end
	end

	// read mux, combinational; unmapped reads return zero
	always_comb begin
		case (reg_addr)
		dtc_pkg::dtc_addr_ctl: reg_rdata = ctl_q;
		dtc_pkg::dtc_addr_mode: reg_rdata = mode_q;
		dtc_pkg::dtc_addr_low_a: reg_rdata = count_low_a_q;
		dtc_pkg::dtc_addr_high_a: reg_rdata = count_high_a_q;
		dtc_pkg::dtc_addr_low_b: reg_rdata = count_low_b_q;
		dtc_pkg::dtc_addr_high_b: reg_rdata = count_high_b_q;
		default: reg_rdata = 8'h00;
		endcase
	end

	assign irq_ovf_a = ctl_q[dtc_pkg::dtc_bit_ovf_a];
	assign irq_ovf_b = ctl_q[dtc_pkg::dtc_bit_ovf_b];
	assign irq_ext_a = ctl_q[dtc_pkg::dtc_bit_eirq_a];
	assign irq_ext_b = ctl_q[dtc_pkg::dtc_bit_eirq_b];
	assign baud_tick = baud_q;

	// overflow flag follows a rollover on the next edge
	ovf_flag_a: assert property (@(posedge clock) disable iff (!resetn)
		ovf_a |=> ctl_q[dtc_pkg::dtc_bit_ovf_a])
		else $error("overflow a did not set its flag");
	// ack without overflow clears the flag
	ack_clear_a: assert property (@(posedge clock) disable iff (!resetn)
		ack_ovf_a && !ovf_a |=> !ctl_q[dtc_pkg::dtc_bit_ovf_a])
		else $error("ack did not clear overflow a");
	// timer b in mode 3 holds its low byte unless written
	hold_b_a: assert property (@(posedge clock) disable iff (!resetn)
		mode_b == dtc_pkg::dtc_mode_split && !reg_wr
		|=> $stable(count_low_b_q))
		else $error("halted timer b changed");
	// reload loads the high byte
	reload_a_a: assert property (@(posedge clock) disable iff (!resetn)
		en_a && mode_a == dtc_pkg::dtc_mode_reload
		&& count_low_a_q == 8'hff && !reg_wr
		|=> count_low_a_q == $past(count_high_a_q))
		else $error("reload value wrong");
	// run bit clear stops timer a low byte
	stop_a_a: assert property (@(posedge clock) disable iff (!resetn)
		!ctl_q[dtc_pkg::dtc_bit_run_a] && !reg_wr
		|=> $stable(count_low_a_q))
		else $error("stopped timer a moved");
	// gate low blocks counting
	gate_block_a: assert property (@(posedge clock) disable iff (!resetn)
		nib_a[dtc_pkg::dtc_nib_gate] && !gate_lvl_a |-> !en_a)
		else $error("gate did not block timer a");
	// 16-bit mode in timer mode steps once per cycle
	step_16_a: assert property (@(posedge clock) disable iff (!resetn)
		en_a && mode_a == dtc_pkg::dtc_mode_16bit && !reg_wr
		|=> count_low_a_q == 8'($past(count_low_a_q) + 8'h01))
		else $error("timer a 16-bit step wrong");
	// split high byte sets timer b flag
	split_ovf_a: assert property (@(posedge clock) disable iff (!resetn)
		en_split_hi && count_high_a_q == 8'hff
		|=> ctl_q[dtc_pkg::dtc_bit_ovf_b])
		else $error("split high byte flag missing");
	cov_reload: cover property (@(posedge clock) ovf_a
		&& mode_a == dtc_pkg::dtc_mode_reload);
	cov_split: cover property (@(posedge clock) en_split_hi && ovf_b);
	cov_baud: cover property (@(posedge clock) baud_q);
endmodule // dtc_timer

// File: verification/dtc_pin_model.sv
/*
 * dtc_pin_model: far side of the timer block, the count and gate pins.
 * assumes the bench calls its tasks; idle pins rest high as if pulled up.
 */
`timescale 1ns/1ps
module dtc_pin_model (
	input wire logic clock,
	output logic count_pin_a,
	output logic count_pin_b,
	output logic ext_gate_pin_a,
	output logic ext_gate_pin_b
);
	// pins rest high, like an open line with a pull-up
	initial begin
		count_pin_a = 1'b1;
		count_pin_b = 1'b1;
		ext_gate_pin_a = 1'b1;
		ext_gate_pin_b = 1'b1;
	end

	// n falling edges; each level held two cycles so two samples land
	task automatic pulse(input int sel, input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge clock);
			if (sel == 0) count_pin_a <= 1'b0;
			else count_pin_b <= 1'b0;
			repeat (2) @(posedge clock);
			if (sel == 0) count_pin_a <= 1'b1;
			else count_pin_b <= 1'b1;
			@(posedge clock);
		end
	endtask

	// gate or interrupt pin level, changed just after an edge
	task automatic gate(input int sel, input logic lvl);
		@(posedge clock);
		if (sel == 0) ext_gate_pin_a <= lvl;
		else ext_gate_pin_b <= lvl;
	endtask
endmodule // dtc_pin_model

// File: verification/tb.sv
/*
 * tb: register-level tests of the dual timer block.
 * assumes the pin model for the far side; reads are combinational.
 */
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin \
	err_count++; $display("MISMATCH t=%0t got %h exp %h", $time, g, e); \
	end end
module tb;
	logic clock = 1'b0;
	logic resetn = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic reg_wr = 1'b0;
	logic [7:0] reg_wdata = 8'h00;
	logic [3:0] ack = 4'h0; // ovf a, ovf b, ext a, ext b
	wire logic [7:0] reg_rdata;
	wire logic [3:0] irq;
	wire logic cpa, cpb, gpa, gpb, baud_tick;
	int err_count = 0;
	int total_checks = 0;
	int baud_cnt = 0;
	int bt;

	always #20 clock = ~clock;

	// baud ticks counted so one overflow must give exactly one
	always @(posedge clock)
		if (baud_tick === 1'b1) baud_cnt <= baud_cnt + 1;

	dtc_pin_model u_pins (.clock(clock), .count_pin_a(cpa),
		.count_pin_b(cpb), .ext_gate_pin_a(gpa), .ext_gate_pin_b(gpb));

	dtc_timer u_dut (.clock(clock), .resetn(resetn),
		.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .count_pin_a(cpa), .count_pin_b(cpb),
		.ext_gate_pin_a(gpa), .ext_gate_pin_b(gpb),
		.ack_ovf_a(ack[0]), .ack_ovf_b(ack[1]), .ack_eirq_a(ack[2]),
		.ack_eirq_b(ack[3]), .irq_ovf_a(irq[0]), .irq_ovf_b(irq[1]),
		.irq_ext_a(irq[2]), .irq_ext_b(irq[3]), .baud_tick(baud_tick));

	task automatic close_out();
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask

	// one-cycle write strobe; strobe drops at the taking edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clock);
		reg_addr <= a;
		@(negedge clock);
		`CHK(reg_rdata, e)
	endtask

	// pin edges need 3-4 cycles to reach the count
	task automatic settle();
		repeat (6) @(posedge clock);
		@(negedge clock);
	endtask

	task automatic ack_p(input int i);
		@(posedge clock);
		ack[i] <= 1'b1;
		@(posedge clock);
		ack[i] <= 1'b0;
		repeat (2) @(negedge clock);
	endtask

	task automatic wait_irq(input int sel, input int lim);
		int i;
		for (i = 0; i < lim && irq[sel] !== 1'b1; i++) @(negedge clock);
		`CHK(irq[sel], 1'b1)
		if (irq[sel] !== 1'b1) close_out();
	endtask

	// hang guard: a stuck run is a failure
	initial begin
		repeat (50000) @(posedge clock);
		err_count++;
		close_out();
	end

	initial begin
		repeat (3) @(posedge clock);
		resetn <= 1'b1;
		// reset values, then an unmapped place
		for (int i = 0; i < 6; i++) rd(8'h88 + i[7:0], 8'h00);
		wr(8'h90, 8'h5a);
		rd(8'h90, 8'h00);
		for (int i = 0; i < 4; i++) wr(8'h8a + i[7:0], 8'h11 * (i[7:0] + 1));
		for (int i = 0; i < 4; i++) rd(8'h8a + i[7:0], 8'h11 * (i[7:0] + 1));
		// timer a, 16-bit counter, rolls over on the third edge
		wr(8'h89, 8'h05);
		wr(8'h8c, 8'hff);
		wr(8'h8a, 8'hfd);
		wr(8'h88, 8'h10);
		u_pins.pulse(0, 3);
		settle();
		rd(8'h8a, 8'h00);
		rd(8'h8c, 8'h00);
		rd(8'h88, 8'h30);
		`CHK(irq[0], 1'b1)
		ack_p(0);
		`CHK(irq[0], 1'b0)
		wr(8'h88, 8'h00);
		u_pins.pulse(0, 2);
		settle();
		rd(8'h8a, 8'h00);
		// mode 0: prescaler carry into the high byte
		wr(8'h89, 8'h04);
		wr(8'h8c, 8'hff);
		wr(8'h8a, 8'h1f);
		wr(8'h88, 8'h10);
		u_pins.pulse(0, 1);
		settle();
		rd(8'h8c, 8'h00);
		rd(8'h8a, 8'h00);
		`CHK(irq[0], 1'b1)
		wr(8'h88, 8'h00);
		// timer b, auto-reload, new reload value while running
		wr(8'h89, 8'h60);
		wr(8'h8d, 8'h40);
		wr(8'h8b, 8'hfe);
		wr(8'h88, 8'h40);
		bt = baud_cnt;
		u_pins.pulse(1, 2);
		settle();
		rd(8'h8b, 8'h40);
		rd(8'h8d, 8'h40);
		rd(8'h88, 8'hc0);
		`CHK(baud_cnt, bt + 1)
		wr(8'h88, 8'h00);
		wr(8'h8b, 8'hff);
		wr(8'h88, 8'h40);
		wr(8'h8d, 8'h80);
		u_pins.pulse(1, 1);
		settle();
		rd(8'h8b, 8'h80);
		wr(8'h88, 8'h00);
		// gate on timer b; level flag follows the low pin
		wr(8'h89, 8'hd0);
		wr(8'h8b, 8'h00);
		u_pins.gate(1, 1'b0);
		wr(8'h88, 8'h40);
		u_pins.pulse(1, 2);
		settle();
		rd(8'h8b, 8'h00);
		`CHK(irq[3], 1'b1)
		ack_p(3);
		`CHK(irq[3], 1'b1)
		u_pins.gate(1, 1'b1);
		u_pins.pulse(1, 2);
		settle();
		rd(8'h8b, 8'h02);
		`CHK(irq[3], 1'b0)
		// edge-type flag on pin a holds until acknowledged
		wr(8'h88, 8'h01);
		u_pins.gate(0, 1'b0);
		settle();
		u_pins.gate(0, 1'b1);
		settle();
		`CHK(irq[2], 1'b1)
		ack_p(2);
		`CHK(irq[2], 1'b0)
		// timer b in mode 3 holds its count even with run set
		wr(8'h88, 8'h00);
		wr(8'h89, 8'h30);
		wr(8'h8b, 8'h55);
		wr(8'h88, 8'h40);
		repeat (20) @(posedge clock);
		rd(8'h8b, 8'h55);
		// timer a split: low byte on its pin, high byte on b's run bit
		wr(8'h88, 8'h00);
		wr(8'h89, 8'h07);
		wr(8'h8c, 8'hfe);
		wr(8'h8a, 8'hff);
		wr(8'h88, 8'h10);
		u_pins.pulse(0, 1);
		settle();
		rd(8'h8a, 8'h00);
		`CHK(irq[0], 1'b1)
		rd(8'h8c, 8'hfe);
		wr(8'h88, 8'h40);
		wait_irq(1, 8);
		ack_p(1);
		`CHK(irq[1], 1'b0)
		wr(8'h88, 8'h00);
		// timer a auto-reload in timer mode, held off by its gate pin
		wr(8'h89, 8'h0a);
		wr(8'h8c, 8'hf0);
		wr(8'h8a, 8'hfe);
		u_pins.gate(0, 1'b0);
		settle();
		wr(8'h88, 8'h10);
		repeat (10) @(posedge clock);
		rd(8'h8a, 8'hfe);
		`CHK(irq[0], 1'b0)
		`CHK(irq[2], 1'b1)
		u_pins.gate(0, 1'b1);
		wait_irq(0, 20);
		wr(8'h88, 8'h00);
		rd(8'h8c, 8'hf0);
		// run for exactly two peripheral cycles between two writes
		wr(8'h8a, 8'h10);
		wr(8'h88, 8'h10);
		wr(8'h88, 8'h00);
		rd(8'h8a, 8'h12);
		close_out();
	end
endmodule // tb
